// File: hdl/dbx_nibble_buf.sv
/*
  Four-nibble transfer buffer storage.
  Assumes the owner arbitrates: one nibble write or one whole-word load per clock.
*/
`timescale 1ns/10ps
module dbx_nibble_buf (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Nibble access
  input  wire logic        nib_we,
  input  wire logic [1:0]  nib_sel,
  input  wire logic [3:0]  nib_wdata,
  // Whole-word load
  input  wire logic        word_we,
  input  wire logic [15:0] word_mask,
  input  wire logic [15:0] word_wdata,
  // Contents
  output logic      [15:0] word
);

  logic [3:0] nib_reg [4];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_nib
      // Nibble g sits at offset g from the base; offset 0 holds the top bits
      always_ff @(posedge clk) begin
        if (rst) begin
          nib_reg[g] <= 4'h0;
        end else if (word_we) begin
          nib_reg[g] <= (nib_reg[g] & ~word_mask[15-4*g -: 4])
                      | (word_wdata[15-4*g -: 4] & word_mask[15-4*g -: 4]);
        end else if (nib_we && nib_sel == 2'(g)) begin
          nib_reg[g] <= nib_wdata;
        end
      end
      assign word[15-4*g -: 4] = nib_reg[g];
    end
  endgenerate

endmodule

// File: hdl/dbx_pkg.sv
/*
  Constants, types and peripheral map for the data buffer transfer block.
  Assumes a core that issues one data-memory, table-read or peripheral
  operation per clock and reads answers one cycle later.
*/
// What this block does
// - Write-only control register reads give undefined value
// - Writes to read-only control registers change nothing
// - Unused control addresses: undefined read, writes ignored
// - Buffer is four nibbles, bank zero, 0CH-0FH
// - MSB is 0CH bit 3, LSB 0FH bit 0
// - All data memory instructions reach buffer nibbles
// - Table read loads program word at pointer
// - Table read consumes one return stack level
// - Small variant reaches only lowest 256 addresses
// - Peripheral read copies selected register into buffer
// - Peripheral write copies buffer into selected register
// - Address 02H: converter compare, eight bits, six used
// - Address 03H: serial shift, write out, read in
// - Addresses 05H, 06H: two pulse duty registers
// - Address 40H: table pointer, 13 or 8 bits
// - Address 41H: synthesizer divide ratio, sixteen bits
// - Address 42H: key drive pattern, sixteen bits
// - Address 43H: frequency count, read only
// - Bad peripheral reads undefined, bad writes ignored
package dbx_pkg;

  // ------------------------------------------------------------
  // Data memory placement
  // ------------------------------------------------------------
  localparam logic [1:0] BUF_BANK      = 2'h0;
  localparam logic [3:0] BUF_ADDR_LO   = 4'hc;
  localparam logic [2:0] CTRL_ROW      = 3'h0;
  localparam logic [3:0] UNDEF_NIBBLE  = 4'hf;

  // ------------------------------------------------------------
  // Peripheral addresses
  // ------------------------------------------------------------
  localparam logic [6:0] PA_ADC_CMP    = 7'h02;
  localparam logic [6:0] PA_SER_SHIFT  = 7'h03;
  localparam logic [6:0] PA_DUTY_ZERO  = 7'h05;
  localparam logic [6:0] PA_DUTY_ONE   = 7'h06;
  localparam logic [6:0] PA_TBL_PTR    = 7'h40;
  localparam logic [6:0] PA_SYNTH_DIV  = 7'h41;
  localparam logic [6:0] PA_KEY_DRIVE  = 7'h42;
  localparam logic [6:0] PA_FREQ_COUNT = 7'h43;

  // ------------------------------------------------------------
  // Widths and masks
  // ------------------------------------------------------------
  localparam int          PTR_W_LARGE  = 13;
  localparam int          PTR_W_SMALL  = 8;
  localparam logic [7:0]  ADC_MASK     = 8'h3f;
  localparam logic [15:0] UNDEF_WORD   = 16'hffff;

  // Operation carried from the core in one cycle
  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_MRD   = 3'b001,
    OP_MWR   = 3'b010,
    OP_TBL   = 3'b011,
    OP_PGET  = 3'b100,
    OP_PPUT  = 3'b101
  } dbx_op_t;

  typedef struct packed {
    dbx_op_t    op;
    logic [1:0] bank;
    logic [6:0] addr;   // data memory address or peripheral address
    logic [3:0] wdata;
  } dbx_req_t;

  typedef enum logic [1:0] {
    TS_IDLE  = 2'b00,
    TS_FETCH = 2'b01,
    TS_LOAD  = 2'b10
  } dbx_tstate_t;

endpackage

// File: hdl/dbx_transfer.sv
/*
  Transfer buffer with table read and peripheral put/get paths.
  Assumes a core issuing one request per clock, a program memory with one
  cycle of read latency, and peripherals that accept a one-cycle load strobe.
*/
`timescale 1ns/10ps
module dbx_transfer #(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int PROG_AW       = 13
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Core request
  input  wire dbx_pkg::dbx_req_t     req,
  output logic                       req_busy,
  output logic [3:0]                 mem_rdata,
  output logic                       stack_take,
  output logic                       stack_give,
  // Control register write-only/read-only/unused map from the core
  input  wire logic [63:0]           ctrl_wo_map,
  input  wire logic [63:0]           ctrl_ro_map,
  input  wire logic [63:0]           ctrl_unused_map,
  input  wire logic [3:0]            ctrl_rdata_in,
  output logic                       ctrl_we,
  output logic [5:0]                 ctrl_waddr,
  output logic [3:0]                 ctrl_wdata,
  // Program memory
  output logic                       prog_re,
  output logic [PROG_AW-1:0]         prog_addr,
  input  wire logic [15:0]           prog_rdata,
  // Peripheral side
  input  wire logic [7:0]            serial_rx_byte,
  input  wire logic [15:0]           freq_count_value,
  output logic                       serial_load,
  output logic [7:0]                 serial_shift_value,
  output logic [7:0]                 adc_compare_value,
  output logic [7:0]                 pulse_duty_zero,
  output logic [7:0]                 pulse_duty_one,
  output logic [15:0]                table_pointer,
  output logic [15:0]                synth_divide_ratio,
  output logic [15:0]                key_drive_pattern,
  // Whole buffer for observation
  output logic [15:0]                transfer_buffer
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  localparam int PTR_W = LARGE_VARIANT ? dbx_pkg::PTR_W_LARGE : dbx_pkg::PTR_W_SMALL;
  localparam logic [15:0] PTR_MASK = 16'((32'h1 << PTR_W) - 1);

  dbx_pkg::dbx_tstate_t tstate_reg;
  logic [15:0]          buf_word;
  logic                 is_buf_nib;
  logic                 is_ctrl;
  logic [5:0]           caddr;
  logic                 nib_we;
  logic                 word_we;
  logic [15:0]          word_mask;
  logic [15:0]          word_wdata;
  logic [15:0]          get_data;
  logic                 get_byte;
  logic                 get_ok;

  assign caddr      = {req.addr[5:4], req.addr[3:0]};
  // Control area is rows 4..7 (address bit 6 set), in any bank: 64 nibbles
  assign is_ctrl    = (req.addr[6] == 1'b1);
  assign is_buf_nib = (req.bank == dbx_pkg::BUF_BANK) && !req.addr[6]
                    && (req.addr[6:4] == dbx_pkg::CTRL_ROW)
                    && (req.addr[3:2] == dbx_pkg::BUF_ADDR_LO[3:2]);

  // ------------------------------------------------------------
  // Buffer storage
  // ------------------------------------------------------------
  dbx_nibble_buf u_buf (
    .clk        (clk),
    .rst        (rst),
    .nib_we     (nib_we),
    .nib_sel    (req.addr[1:0]),
    .nib_wdata  (req.wdata),
    .word_we    (word_we),
    .word_mask  (word_mask),
    .word_wdata (word_wdata),
    .word       (buf_word)
  );

  // ------------------------------------------------------------
  // Peripheral read decode
  // ------------------------------------------------------------
  always_comb begin
    get_data = dbx_pkg::UNDEF_WORD;
    get_byte = 1'b0;
    get_ok   = 1'b1;
    case (req.addr)
      dbx_pkg::PA_ADC_CMP: begin
        get_data = {8'h00, adc_compare_value};
        get_byte = 1'b1;
      end
      dbx_pkg::PA_SER_SHIFT: begin
        get_data = {8'h00, serial_rx_byte};
        get_byte = 1'b1;
      end
      dbx_pkg::PA_DUTY_ZERO: begin
        get_data = {8'h00, pulse_duty_zero};
        get_byte = 1'b1;
      end
      dbx_pkg::PA_DUTY_ONE: begin
        get_data = {8'h00, pulse_duty_one};
        get_byte = 1'b1;
      end
      dbx_pkg::PA_TBL_PTR:    get_data = table_pointer;
      dbx_pkg::PA_SYNTH_DIV:  get_data = synth_divide_ratio;
      dbx_pkg::PA_KEY_DRIVE:  get_data = key_drive_pattern;
      dbx_pkg::PA_FREQ_COUNT: get_data = freq_count_value;
      default:                get_ok   = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Buffer write arbitration
  // ------------------------------------------------------------
  always_comb begin
    nib_we     = 1'b0;
    word_we    = 1'b0;
    word_mask  = 16'hffff;
    word_wdata = get_data;
    if (tstate_reg == dbx_pkg::TS_LOAD) begin
      word_we    = 1'b1;
      word_wdata = prog_rdata;
    end else if (req.op == dbx_pkg::OP_MWR && is_buf_nib) begin
      nib_we = 1'b1;
    end else if (req.op == dbx_pkg::OP_PGET) begin
      // Unused address loads the undefined pattern, as the core sees it
      word_we   = 1'b1;
      word_mask = (get_byte && get_ok) ? 16'h00ff : 16'hffff;
    end
  end

  // ------------------------------------------------------------
  // Table read sequence
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tstate_reg <= dbx_pkg::TS_IDLE;
    end else begin
      case (tstate_reg)
        dbx_pkg::TS_IDLE:
          if (req.op == dbx_pkg::OP_TBL) tstate_reg <= dbx_pkg::TS_FETCH;
        dbx_pkg::TS_FETCH: tstate_reg <= dbx_pkg::TS_LOAD;
        dbx_pkg::TS_LOAD:  tstate_reg <= dbx_pkg::TS_IDLE;
        default:           tstate_reg <= dbx_pkg::TS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      req_busy   <= 1'b0;
      prog_re    <= 1'b0;
      prog_addr  <= '0;
      stack_take <= 1'b0;
      stack_give <= 1'b0;
    end else begin
      req_busy   <= (tstate_reg == dbx_pkg::TS_IDLE && req.op == dbx_pkg::OP_TBL)
                 || (tstate_reg == dbx_pkg::TS_FETCH);
      prog_re    <= (tstate_reg == dbx_pkg::TS_IDLE && req.op == dbx_pkg::OP_TBL);
      // Small variant: upper pointer bits masked, so only the low page is reached
      prog_addr  <= PROG_AW'(table_pointer & PTR_MASK);
      stack_take <= (tstate_reg == dbx_pkg::TS_IDLE && req.op == dbx_pkg::OP_TBL);
      stack_give <= (tstate_reg == dbx_pkg::TS_LOAD);
    end
  end

  // ------------------------------------------------------------
  // Peripheral registers written by put
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      adc_compare_value  <= 8'h00;
      serial_shift_value <= 8'h00;
      serial_load        <= 1'b0;
      pulse_duty_zero    <= 8'h00;
      pulse_duty_one     <= 8'h00;
      table_pointer      <= 16'h0000;
      synth_divide_ratio <= 16'h0000;
      key_drive_pattern  <= 16'h0000;
    end else begin
      serial_load <= 1'b0;
      if (req.op == dbx_pkg::OP_PPUT && tstate_reg == dbx_pkg::TS_IDLE) begin
        case (req.addr)
          dbx_pkg::PA_ADC_CMP:   adc_compare_value <= buf_word[7:0] & dbx_pkg::ADC_MASK;
          dbx_pkg::PA_SER_SHIFT: begin
            serial_shift_value <= buf_word[7:0];
            serial_load        <= 1'b1;
          end
          dbx_pkg::PA_DUTY_ZERO: pulse_duty_zero    <= buf_word[7:0];
          dbx_pkg::PA_DUTY_ONE:  pulse_duty_one     <= buf_word[7:0];
          dbx_pkg::PA_TBL_PTR:   table_pointer      <= buf_word & PTR_MASK;
          dbx_pkg::PA_SYNTH_DIV: synth_divide_ratio <= buf_word;
          dbx_pkg::PA_KEY_DRIVE: key_drive_pattern  <= buf_word;
          // Count register and unused addresses take no write
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Data memory read and control area access
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_rdata  <= 4'h0;
      ctrl_we    <= 1'b0;
      ctrl_waddr <= 6'h00;
      ctrl_wdata <= 4'h0;
    end else begin
      ctrl_we    <= 1'b0;
      ctrl_waddr <= caddr;
      ctrl_wdata <= req.wdata;
      if (req.op == dbx_pkg::OP_MRD) begin
        if (is_buf_nib) begin
          mem_rdata <= buf_word[15-4*req.addr[1:0] -: 4];
        end else if (is_ctrl && (ctrl_wo_map[caddr] || ctrl_unused_map[caddr])) begin
          mem_rdata <= dbx_pkg::UNDEF_NIBBLE;
        end else begin
          mem_rdata <= ctrl_rdata_in;
        end
      end
      if (req.op == dbx_pkg::OP_MWR && is_ctrl) begin
        ctrl_we <= !(ctrl_ro_map[caddr] || ctrl_unused_map[caddr]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      transfer_buffer <= 16'h0000;
    end else begin
      transfer_buffer <= buf_word;
    end
  end

endmodule

// File: tb/dbx_periph_model.sv
/*
  Program memory and peripheral inputs seen by the transfer block.
  Assumes one fetch strobe per word; data valid only the cycle after it.
*/
`timescale 1ns/10ps
module dbx_periph_model #(
  parameter int         PROG_AW    = 13,
  parameter logic [7:0]  RX_BYTE    = 8'h3c,
  parameter logic [15:0] FREQ_VALUE = 16'h4e1f
) (
  // Clock
  input  wire logic               clk,
  // Program memory
  input  wire logic               prog_re,
  input  wire logic [PROG_AW-1:0] prog_addr,
  output logic      [15:0]        prog_rdata,
  // Peripheral inputs
  output logic      [7:0]         serial_rx_byte,
  output logic      [15:0]        freq_count_value
);
  logic               valid_reg = 1'b0;
  logic [PROG_AW-1:0] addr_reg  = '0;
  logic [15:0]        junk_reg  = 16'h0;
  always_ff @(posedge clk) begin
    valid_reg <= prog_re;
    addr_reg  <= prog_addr;
    junk_reg  <= junk_reg + 16'h1357;
  end
  // Outside the valid cycle the bus churns so stale data cannot pass
  assign prog_rdata       = valid_reg ? (16'(addr_reg) ^ 16'ha5c3) : junk_reg;
  assign serial_rx_byte   = RX_BYTE;
  assign freq_count_value = FREQ_VALUE;
endmodule

// File: tb/dbx_transfer_monitor.sv
/*
  Port checker for the transfer block.
  Assumes it is bound to every dbx_transfer instance with its parameters.
*/
`timescale 1ns/10ps
module dbx_transfer_monitor #(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int PROG_AW       = 13
) (
  // Clock, reset, request
  input wire logic                clk,
  input wire logic                rst,
  input wire dbx_pkg::dbx_req_t   req,
  // Core answers
  input wire logic                req_busy,
  input wire logic [3:0]          mem_rdata,
  input wire logic                stack_take,
  input wire logic                stack_give,
  // Control area
  input wire logic [63:0]         ctrl_wo_map,
  input wire logic [63:0]         ctrl_ro_map,
  input wire logic [63:0]         ctrl_unused_map,
  input wire logic                ctrl_we,
  input wire logic [5:0]          ctrl_waddr,
  input wire logic [3:0]          ctrl_wdata,
  // Program memory and peripherals
  input wire logic                prog_re,
  input wire logic [PROG_AW-1:0]  prog_addr,
  input wire logic                serial_load,
  input wire logic [7:0]          adc_compare_value,
  input wire logic [15:0]         table_pointer,
  input wire logic [15:0]         synth_divide_ratio,
  input wire logic [15:0]         key_drive_pattern
);
  localparam int PW = LARGE_VARIANT ? dbx_pkg::PTR_W_LARGE : dbx_pkg::PTR_W_SMALL;
  logic        ctl_sel;
  logic [63:0] ctrl_shut;
  logic [63:0] ctrl_hidden;
  // Writes that must be dropped, reads that must come back undefined
  assign ctrl_shut   = ctrl_ro_map | ctrl_unused_map;
  assign ctrl_hidden = ctrl_wo_map | ctrl_unused_map;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Control-area access only counts while no table read holds the core
  assign ctl_sel = req.addr[6] && !req_busy;
  table_fetch_a: assert property (
    req.op == dbx_pkg::OP_TBL && !req_busy |=> prog_re && stack_take && req_busy ##1 req_busy)
    else $error("table read did not start");
  stack_pair_a: assert property (stack_take |-> ##2 stack_give)
    else $error("stack level not returned");
  fetch_addr_a: assert property (prog_re |-> prog_addr == table_pointer[PROG_AW-1:0])
    else $error("fetch address differs from pointer");
  ptr_width_a: assert property ((table_pointer >> PW) == 16'h0)
    else $error("pointer wider than variant allows");
  adc_bits_a: assert property (adc_compare_value[7:6] == 2'h0)
    else $error("compare value beyond six bits");
  ser_load_a: assert property (
    serial_load |-> $past(req.op) == dbx_pkg::OP_PPUT && $past(req.addr) == dbx_pkg::PA_SER_SHIFT)
    else $error("serial load without put");
  ser_pulse_a: assert property (
    req.op == dbx_pkg::OP_PPUT && req.addr == dbx_pkg::PA_SER_SHIFT && !req_busy |=> serial_load)
    else $error("serial put gave no load strobe");
  freq_put_a: assert property (
    req.op == dbx_pkg::OP_PPUT && req.addr == dbx_pkg::PA_FREQ_COUNT |=> !serial_load
    && $stable({table_pointer, synth_divide_ratio, key_drive_pattern, adc_compare_value}))
    else $error("put to read-only register changed state");
  ctrl_block_a: assert property (
    req.op == dbx_pkg::OP_MWR && ctl_sel && ctrl_shut[req.addr[5:0]]
    |=> !ctrl_we) else $error("blocked control write forwarded");
  ctrl_pass_a: assert property (
    req.op == dbx_pkg::OP_MWR && ctl_sel && !ctrl_shut[req.addr[5:0]]
    |=> ctrl_we && {1'b1, ctrl_waddr} == $past(req.addr) && ctrl_wdata == $past(req.wdata))
    else $error("control write not forwarded");
  ctrl_undef_a: assert property (
    req.op == dbx_pkg::OP_MRD && ctl_sel && ctrl_hidden[req.addr[5:0]]
    |=> mem_rdata == dbx_pkg::UNDEF_NIBBLE) else $error("hidden control value read");
endmodule
bind dbx_transfer dbx_transfer_monitor #(.LARGE_VARIANT(LARGE_VARIANT), .PROG_AW(PROG_AW))
  mon (.*);

// File: tb/test_dbx_transfer.sv
/*
  Self-checking bench for the transfer block.
  Assumes the peripheral model and the bound port checker.
*/
`timescale 1ns/10ps
`define CHK(name, exp, got) begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected %s expected %h seen %h", name, exp, got); end end
module test_dbx_transfer;
  localparam logic [7:0]  RX   = 8'h3c;
  localparam logic [15:0] FREQ = 16'h4e1f;
  logic clk, rst, req_busy, stack_take, stack_give, ctrl_we, prog_re, serial_load;
  dbx_pkg::dbx_req_t req;
  logic [63:0] ctrl_wo_map, ctrl_ro_map, ctrl_unused_map;
  logic [3:0]  ctrl_rdata_in, mem_rdata, ctrl_wdata;
  logic [5:0]  ctrl_waddr;
  logic [12:0] prog_addr;
  logic [7:0]  serial_rx_byte, serial_shift_value, adc_compare_value, pulse_duty_zero;
  logic [7:0]  pulse_duty_one;
  logic [15:0] prog_rdata, freq_count_value, table_pointer, synth_divide_ratio;
  logic [15:0] key_drive_pattern, transfer_buffer;
  logic [6:0]  pa [9] = '{7'h02, 7'h03, 7'h05, 7'h06, 7'h40, 7'h41, 7'h42, 7'h43, 7'h07};
  int errors = 0, check_count = 0, cycles = 0;
  dbx_transfer #(.LARGE_VARIANT(1'b1), .PROG_AW(13)) dut (.*);
  dbx_periph_model #(.PROG_AW(13), .RX_BYTE(RX), .FREQ_VALUE(FREQ)) far (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Request for one cycle; returns after the answer edge has settled
  task automatic issue(dbx_pkg::dbx_op_t o, logic [6:0] a, logic [3:0] d);
    @(posedge clk) req <= '{o, 2'h0, a, d};
    @(posedge clk) req <= '{dbx_pkg::OP_NONE, 2'h0, 7'h0, 4'h0};
    @(posedge clk) #1;
  endtask
  task automatic wr_word(logic [15:0] w);
    for (int i = 0; i < 4; i++) issue(dbx_pkg::OP_MWR, 7'h0c + 7'(i), w[15-4*i -: 4]);
  endtask
  function automatic logic [15:0] reg_of(logic [6:0] a);
    case (a)
      7'h02: return {8'h0, adc_compare_value};
      7'h03: return {8'h0, serial_shift_value};
      7'h05: return {8'h0, pulse_duty_zero};
      7'h06: return {8'h0, pulse_duty_one};
      7'h40: return table_pointer;
      7'h42: return key_drive_pattern;
      default: return synth_divide_ratio;
    endcase
  endfunction
  // Register content expected after a put of 16'hb6d9
  function automatic logic [15:0] exp_put(logic [6:0] a);
    case (a)
      7'h02: return 16'h0019;
      7'h03, 7'h05, 7'h06: return 16'h00d9;
      7'h40: return 16'h16d9;
      default: return 16'hb6d9;
    endcase
  endfunction
  function automatic logic [15:0] exp_get(logic [6:0] a);
    case (a)
      7'h02: return 16'h5a19;
      7'h03: return {8'h5a, RX};
      7'h05, 7'h06: return 16'h5ad9;
      7'h40: return 16'h16d9;
      7'h41, 7'h42: return 16'hb6d9;
      7'h43: return FREQ;
      default: return 16'hffff;
    endcase
  endfunction
  initial begin
    rst = 1'b1;
    req = '{dbx_pkg::OP_NONE, 2'h0, 7'h0, 4'h0};
    ctrl_wo_map = 64'h20;
    ctrl_ro_map = 64'h40;
    ctrl_unused_map = 64'h80;
    ctrl_rdata_in = 4'h9;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // ----------------------------------------------------------
    // Buffer layout and direct nibble access
    // ----------------------------------------------------------
    wr_word(16'h1234);
    `CHK("buffer word", 16'h1234, transfer_buffer)
    for (int i = 0; i < 4; i++) begin
      issue(dbx_pkg::OP_MRD, 7'h0c + 7'(i), 4'h0);
      `CHK("buffer nibble", 4'(16'h1234 >> (12 - 4*i)), mem_rdata)
    end
    // ----------------------------------------------------------
    // Put then get on every peripheral address and one unused
    // ----------------------------------------------------------
    for (int k = 0; k < 9; k++) begin
      // Last two puts carry a fresh word that must land nowhere
      wr_word((k < 7) ? 16'hb6d9 : 16'hc3a5);
      issue(dbx_pkg::OP_PPUT, pa[k], 4'h0);
      `CHK("register after put", exp_put(pa[k]), reg_of(pa[k]))
      wr_word(16'h5a5a);
      issue(dbx_pkg::OP_PGET, pa[k], 4'h0);
      `CHK("buffer after get", exp_get(pa[k]), transfer_buffer)
    end
    `CHK("compare after bad puts", 8'h19, adc_compare_value)
    `CHK("serial after bad puts", 8'hd9, serial_shift_value)
    `CHK("duty after bad puts", 16'hd9d9, {pulse_duty_zero, pulse_duty_one})
    `CHK("pointer after bad puts", 16'h16d9, table_pointer)
    `CHK("pattern after bad puts", 16'hb6d9, key_drive_pattern)
    // ----------------------------------------------------------
    // Table read through the pointer, then control area
    // ----------------------------------------------------------
    wr_word(16'h1123);
    issue(dbx_pkg::OP_PPUT, 7'h40, 4'h0);
    issue(dbx_pkg::OP_TBL, 7'h0, 4'h0);
    `CHK("busy in table read", 1'b1, req_busy)
    repeat (2) @(posedge clk);
    #1;
    `CHK("table word", 16'h1123 ^ 16'ha5c3, transfer_buffer)
    issue(dbx_pkg::OP_MWR, 7'h46, 4'h3);
    issue(dbx_pkg::OP_MWR, 7'h44, 4'h3);
    issue(dbx_pkg::OP_MRD, 7'h45, 4'h0);
    `CHK("write-only read", 4'hf, mem_rdata)
    issue(dbx_pkg::OP_MRD, 7'h47, 4'h0);
    `CHK("unused read", 4'hf, mem_rdata)
    issue(dbx_pkg::OP_MRD, 7'h44, 4'h0);
    `CHK("control read", 4'h9, mem_rdata)
    print_verdict();
  end
endmodule
